// >>> mode_access_regs.vh
// constants for cpu mode and memory access control
// assumes byte addresses on a 20-bit cpu bus, one clock, active-low async reset
`ifndef MODE_ACCESS_REGS_VH
`define MODE_ACCESS_REGS_VH

`define MODE_BOOT 3'h0
`define MODE_TEST 3'h1
`define MODE_FIRMWARE 3'h2
`define MODE_SYSTEM 3'h3
`define MODE_USER 3'h4

`define APP_ROM_BASE 20'h00000
`define APP_ROM_SIZE 20'h60000
`define TEST_ROM_BASE 20'h60000
`define TEST_ROM_SIZE 20'h20000
`define EE_BASE 20'h80000
`define EE_SIZE 20'h14000
`define EE_MAKER_SIZE 20'h00200
`define EE_SUPPORT_SIZE 20'h00300
`define RAM_BASE 20'hc0000
`define RAM_FW_SIZE 20'h00200
`define RAM_GEN_SIZE 20'h01400
`define RAM_COP_SIZE 20'h00a80

`define EXC_VEC_BASE 20'h00000
`define IRQ_VEC_BASE 20'h00100
`define SYSTEM_CALL_VECTOR_BASE 20'h00200
`define FIRMWARE_CALL_VECTOR_BASE 20'h60100
`define VEC_STRIDE 20'h00004
`define EXC_COUNT 4
`define IRQ_COUNT 16
`define FIRMWARE_CALL_VECTOR_COUNT 8
`define SYSTEM_CALL_VECTOR_COUNT 32

`endif

// >>> region_decode.v
// address decoder giving one-hot memory region membership, all zero outside the mapped regions
// assumes constants from mode_access_regs.vh, purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "mode_access_regs.vh"
module region_decode (
	input wire [19:0] addr,
	output reg app_rom,
	output reg test_rom,
	output reg ee_maker,
	output reg ee_support,
	output reg ee_app,
	output reg ram_fw,
	output reg ram_gen,
	output reg ram_cop
);
	wire [19:0] ee_off;
	wire [19:0] ram_off;
	assign ee_off = addr - `EE_BASE;
	assign ram_off = addr - `RAM_BASE;
	always @* begin
		app_rom = addr < `APP_ROM_BASE + `APP_ROM_SIZE;
		test_rom = addr >= `TEST_ROM_BASE && addr < `TEST_ROM_BASE + `TEST_ROM_SIZE;
		ee_maker = addr >= `EE_BASE && ee_off < `EE_MAKER_SIZE;
		ee_support = addr >= `EE_BASE && ee_off >= `EE_MAKER_SIZE &&
			ee_off < `EE_MAKER_SIZE + `EE_SUPPORT_SIZE;
		ee_app = addr >= `EE_BASE && ee_off >= `EE_MAKER_SIZE + `EE_SUPPORT_SIZE &&
			ee_off < `EE_SIZE;
		ram_fw = addr >= `RAM_BASE && ram_off < `RAM_FW_SIZE;
		ram_gen = addr >= `RAM_BASE && ram_off >= `RAM_FW_SIZE &&
			ram_off < `RAM_FW_SIZE + `RAM_GEN_SIZE;
		ram_cop = addr >= `RAM_BASE && ram_off >= `RAM_FW_SIZE + `RAM_GEN_SIZE &&
			ram_off < `RAM_FW_SIZE + `RAM_GEN_SIZE + `RAM_COP_SIZE;
	end
endmodule
`default_nettype wire

// >>> mode_access_ctrl.v
// cpu mode tracker and memory access checker
// assumes the cpu core presents one request per cycle and stalls on the redirect
`timescale 1ns/1ps
`default_nettype none
`include "mode_access_regs.vh"
module mode_access_ctrl #(
	parameter USER_WINDOWS = 4
) (
	input wire core_clk,
	input wire arst_n,
	input wire test_fuse_blown,
	input wire production_end,
	input wire boot_done,
	input wire chip_health_en,
	input wire health_req,
	input wire health_sel_ident,
	input wire pdc_en,
	input wire pdc_lock,
	input wire pdc_write,
	input wire exc_req,
	input wire [1:0] exc_num,
	input wire irq_req,
	input wire [3:0] irq_num,
	input wire return_user,
	input wire return_system,
	input wire cpu_req,
	input wire cpu_write,
	input wire cpu_fetch,
	input wire [19:0] cpu_addr,
	input wire mmu_write,
	input wire [1:0] mmu_idx,
	input wire [19:0] mmu_base,
	input wire [19:0] mmu_limit,
	input wire mmu_allow_write,
	input wire cop_req,
	input wire [19:0] cop_addr,
	output reg [2:0] cpu_mode,
	output reg privileged,
	output reg cpu_grant,
	output reg cpu_fault,
	output reg cop_grant,
	output reg cop_fault,
	output reg redirect_valid,
	output reg [19:0] redirect_addr,
	output reg test_disabled,
	output reg health_self_test,
	output reg health_ident,
	output reg pdc_accept,
	output reg pdc_refused
);
	////////////////////////////////////////////////////////////////////////
	// mode state
	reg [2:0] mode_next;
	reg test_dis_reg;
	reg fuse_seen_reg;
	wire fw_vec_hit;
	wire sys_vec_hit;
	wire [19:0] fw_off;
	wire [19:0] sys_off;
	assign fw_off = cpu_addr - `FIRMWARE_CALL_VECTOR_BASE;
	assign sys_off = cpu_addr - `SYSTEM_CALL_VECTOR_BASE;
	// a call is a fetch landing on the vector table, nothing else enters firmware mode
	assign fw_vec_hit = cpu_req && cpu_fetch && cpu_addr >= `FIRMWARE_CALL_VECTOR_BASE && fw_off[1:0] == 2'h0 &&
		fw_off < `FIRMWARE_CALL_VECTOR_COUNT * `VEC_STRIDE;
	assign sys_vec_hit = cpu_req && cpu_fetch && cpu_addr >= `SYSTEM_CALL_VECTOR_BASE && sys_off[1:0] == 2'h0 &&
		sys_off < `SYSTEM_CALL_VECTOR_COUNT * `VEC_STRIDE;

	// fuse is sampled after reset release, the flop itself resets to a constant
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			test_dis_reg <= 1'b0;
			fuse_seen_reg <= 1'b0;
		end else begin
			fuse_seen_reg <= 1'b1;
			if (!fuse_seen_reg && test_fuse_blown)
				test_dis_reg <= 1'b1;
			else if (production_end)
				test_dis_reg <= 1'b1;
		end
	end

	always @* begin
		mode_next = cpu_mode;
		case (cpu_mode)
		`MODE_BOOT: begin
			if (boot_done && fuse_seen_reg)
				mode_next = test_dis_reg ? `MODE_SYSTEM : `MODE_TEST;
		end
		`MODE_TEST: begin
			if (production_end)
				mode_next = `MODE_SYSTEM;
		end
		`MODE_FIRMWARE: begin
			if (return_system)
				mode_next = `MODE_SYSTEM;
			else if (return_user)
				mode_next = `MODE_USER;
		end
		`MODE_SYSTEM, `MODE_USER: begin
			if (fw_vec_hit)
				mode_next = `MODE_FIRMWARE;
			else if (sys_vec_hit || exc_req || irq_req)
				mode_next = `MODE_SYSTEM;
			else if (cpu_mode == `MODE_SYSTEM && return_user)
				mode_next = `MODE_USER;
		end
		default: mode_next = `MODE_BOOT;
		endcase
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cpu_mode <= `MODE_BOOT;
			privileged <= 1'b1;
			test_disabled <= 1'b0;
		end else begin
			cpu_mode <= mode_next;
			privileged <= mode_next == `MODE_BOOT || mode_next == `MODE_TEST ||
				mode_next == `MODE_FIRMWARE;
			test_disabled <= test_dis_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// exception and interrupt vectors
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			redirect_valid <= 1'b0;
			redirect_addr <= 20'h00000;
		end else begin
			redirect_valid <= 1'b0;
			if (exc_req && !privileged) begin
				redirect_valid <= 1'b1;
				redirect_addr <= `EXC_VEC_BASE + {16'h0000, exc_num, 2'h0};
			end else if (irq_req && !privileged) begin
				redirect_valid <= 1'b1;
				redirect_addr <= `IRQ_VEC_BASE + {14'h0000, irq_num, 2'h0};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// user windows, writable from system mode only
	reg [19:0] win_base [0:USER_WINDOWS-1];
	reg [19:0] win_limit [0:USER_WINDOWS-1];
	reg [USER_WINDOWS-1:0] win_wr;
	reg [USER_WINDOWS-1:0] win_hit;
	genvar gi;
	generate
		for (gi = 0; gi < USER_WINDOWS; gi = gi + 1) begin : g_win
			always @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					win_base[gi] <= 20'h00000;
					win_limit[gi] <= 20'h00000;
					win_wr[gi] <= 1'b0;
				end else if (mmu_write && cpu_mode == `MODE_SYSTEM && mmu_idx == gi) begin
					win_base[gi] <= mmu_base;
					win_limit[gi] <= mmu_limit;
					win_wr[gi] <= mmu_allow_write;
				end
			end
			always @* begin
				win_hit[gi] = cpu_addr >= win_base[gi] && cpu_addr < win_limit[gi] &&
					(!cpu_write || win_wr[gi]);
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// cpu access check
	wire c_app_rom, c_test_rom, c_ee_maker, c_ee_support, c_ee_app;
	wire c_ram_fw, c_ram_gen, c_ram_cop;
	region_decode u_cpu_dec (
		.addr(cpu_addr),
		.app_rom(c_app_rom),
		.test_rom(c_test_rom),
		.ee_maker(c_ee_maker),
		.ee_support(c_ee_support),
		.ee_app(c_ee_app),
		.ram_fw(c_ram_fw),
		.ram_gen(c_ram_gen),
		.ram_cop(c_ram_cop)
	);
	reg cpu_ok;
	reg [2:0] eff_mode;
	always @* begin
		// checking against the next mode lets a vector fetch use the new window
		eff_mode = (fw_vec_hit || sys_vec_hit) ? mode_next : cpu_mode;
		cpu_ok = 1'b0;
		case (eff_mode)
		`MODE_TEST: cpu_ok = 1'b1;
		`MODE_BOOT, `MODE_FIRMWARE:
			cpu_ok = c_test_rom || c_ee_maker || c_ee_support || c_ram_fw;
		`MODE_SYSTEM:
			cpu_ok = c_app_rom || c_ee_app || c_ram_gen || c_ram_cop;
		`MODE_USER:
			cpu_ok = (c_app_rom || c_ee_app || c_ram_gen || c_ram_cop) && |win_hit;
		default: cpu_ok = 1'b0;
		endcase
		// rom is never written outside test mode
		if (cpu_write && (c_app_rom || c_test_rom) && eff_mode != `MODE_TEST)
			cpu_ok = 1'b0;
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cpu_grant <= 1'b0;
			cpu_fault <= 1'b0;
		end else begin
			cpu_grant <= cpu_req && cpu_ok;
			cpu_fault <= cpu_req && !cpu_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// coprocessor check, no user windows involved
	wire p_ram_cop;
	region_decode u_cop_dec (
		.addr(cop_addr),
		.app_rom(),
		.test_rom(),
		.ee_maker(),
		.ee_support(),
		.ee_app(),
		.ram_fw(),
		.ram_gen(),
		.ram_cop(p_ram_cop)
	);
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cop_grant <= 1'b0;
			cop_fault <= 1'b0;
		end else begin
			cop_grant <= cop_req && p_ram_cop;
			cop_fault <= cop_req && !p_ram_cop;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// chip health and post delivery configuration
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			health_self_test <= 1'b0;
			health_ident <= 1'b0;
			pdc_accept <= 1'b0;
			pdc_refused <= 1'b0;
		end else begin
			health_self_test <= cpu_mode == `MODE_BOOT && chip_health_en && health_req &&
				!health_sel_ident;
			health_ident <= cpu_mode == `MODE_BOOT && chip_health_en && health_req &&
				health_sel_ident;
			pdc_accept <= pdc_write && pdc_en && !pdc_lock &&
				cpu_mode == `MODE_FIRMWARE;
			pdc_refused <= pdc_write && !(pdc_en && !pdc_lock &&
				cpu_mode == `MODE_FIRMWARE);
		end
	end
endmodule
`default_nettype wire

// >>> mode_access_props.sv
// checker for the mode and access controller ports
// assumes mode codes and map from mode_access_regs.vh
`timescale 1ns/1ps
`default_nettype none
`include "mode_access_regs.vh"
module mode_access_props #(parameter USER_WINDOWS = 4) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic exc_req,
	input wire logic [1:0] exc_num,
	input wire logic irq_req,
	input wire logic cpu_req,
	input wire logic cpu_fetch,
	input wire logic [19:0] cpu_addr,
	input wire logic pdc_write,
	input wire logic pdc_lock,
	input wire logic cop_req,
	input wire logic [19:0] cop_addr,
	input wire logic [2:0] cpu_mode,
	input wire logic privileged,
	input wire logic cpu_grant,
	input wire logic cpu_fault,
	input wire logic cop_grant,
	input wire logic cop_fault,
	input wire logic redirect_valid,
	input wire logic [19:0] redirect_addr,
	input wire logic test_disabled,
	input wire logic pdc_refused
);
default clocking @(posedge core_clk); endclocking
default disable iff (!arst_n);
wire in_cop = cop_addr >= 20'hc1600 && cop_addr < 20'hc2080;
////////////////////////////////////////
sequence firmware_call_vector_fetch;
	cpu_req && cpu_fetch && !privileged && cpu_addr[19:5] == 15'h3008 && cpu_addr[1:0] == 2'h0;
endsequence
sequence fw_entered;
	cpu_grant && cpu_mode == `MODE_FIRMWARE && privileged;
endsequence
sequence system_call_vector_fetch;
	cpu_req && cpu_fetch && cpu_mode == `MODE_USER && cpu_addr[19:7] == 13'h4 && !cpu_addr[1:0];
endsequence
AST_PRIV: assert property (cpu_mode <= `MODE_USER && privileged == (cpu_mode < `MODE_SYSTEM))
	else $error("mode group and privilege disagree");
AST_FIRMWARE_CALL_VECTOR: assert property (firmware_call_vector_fetch |=> fw_entered)
	else $error("firmware vector did not enter firmware mode");
AST_SYSTEM_CALL_VECTOR: assert property (system_call_vector_fetch |=> cpu_mode == `MODE_SYSTEM && !privileged)
	else $error("system call vector did not enter system mode");
AST_EXC: assert property (exc_req && !irq_req && !privileged && !cpu_req |=> redirect_valid && redirect_addr == {16'h0, $past(exc_num), 2'h0})
	else $error("exception vector wrong");
AST_TEST_FREE: assert property (cpu_mode == `MODE_TEST && cpu_req && !cpu_fetch |=> cpu_grant && !cpu_fault)
	else $error("test mode access refused");
AST_FW_WIN: assert property (cpu_mode == `MODE_FIRMWARE && cpu_req && !cpu_fetch && cpu_addr < `TEST_ROM_BASE |=> cpu_fault && !cpu_grant)
	else $error("firmware reached application rom");
AST_COP: assert property (cop_req |=> cop_grant == $past(in_cop) && cop_fault != $past(in_cop))
	else $error("coprocessor check wrong");
AST_TEST_OFF: assert property (test_disabled |=> test_disabled && cpu_mode != `MODE_TEST)
	else $error("test disable lost");
AST_PDC: assert property (pdc_write && pdc_lock |=> pdc_refused)
	else $error("locked configuration change not refused");
endmodule
bind mode_access_ctrl mode_access_props #(.USER_WINDOWS(USER_WINDOWS)) mode_access_props_inst (
	.core_clk, .arst_n, .exc_req, .exc_num, .irq_req, .cpu_req, .cpu_fetch, .cpu_addr, .pdc_write,
	.pdc_lock, .cop_req, .cop_addr, .cpu_mode, .privileged, .cpu_grant, .cpu_fault, .cop_grant,
	.cop_fault, .redirect_valid, .redirect_addr, .test_disabled, .pdc_refused);
`default_nettype wire

// >>> core_model.sv
// far side: cpu core and coprocessor issuing single accesses
// assumes the bench raises go or cop_go for one falling edge per access
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic core_clk,
	input wire logic go,
	input wire logic fetch,
	input wire logic write,
	input wire logic [19:0] addr,
	input wire logic cop_go,
	output logic cpu_req,
	output logic cpu_fetch,
	output logic cpu_write,
	output logic [19:0] cpu_addr,
	output logic cop_req,
	output logic [19:0] cop_addr
);
initial begin
	{cpu_req, cpu_fetch, cpu_write, cop_req} = 4'h0;
	{cpu_addr, cop_addr} = 40'h0;
end
// idle address lines flip so a stale address never looks valid
always @(negedge core_clk) begin
	cpu_req <= go;
	cpu_fetch <= go & fetch;
	cpu_write <= go & write;
	cpu_addr <= go ? addr : ~cpu_addr;
	cop_req <= cop_go;
	cop_addr <= cop_go ? addr : ~cop_addr;
end
endmodule
`default_nettype wire

// >>> cpu_mode_memory_access_control_test.sv
// self-checking bench for the mode and access controller
// assumes core_model drives the access ports; checker is bound
`timescale 1ns/1ps
`default_nettype none
`include "mode_access_regs.vh"
module cpu_mode_memory_access_control_test;
logic core_clk, arst_n, fuse, pend, bdone, hen, hreq, hsel, pen, plock, pwr;
logic exc, irq, rus, rsy, mw, go, fetch, write, cop_go;
logic [1:0] exc_num;
logic [3:0] irq_num;
logic [19:0] addr;
wire cpu_req, cpu_fetch, cpu_write, cop_req, priv, grant, fault, cgrant, cfault, rv, td;
wire hst, hid, pacc, pref;
wire [19:0] cpu_addr, cop_addr, raddr;
wire [2:0] mode;
int err_count, checks_done;
mode_access_ctrl #(.USER_WINDOWS(4)) mode_access_ctrl_inst (.core_clk(core_clk), .arst_n(arst_n),
	.test_fuse_blown(fuse), .production_end(pend), .boot_done(bdone), .chip_health_en(hen),
	.health_req(hreq), .health_sel_ident(hsel), .pdc_en(pen), .pdc_lock(plock), .pdc_write(pwr),
	.exc_req(exc), .exc_num(exc_num), .irq_req(irq), .irq_num(irq_num), .return_user(rus),
	.return_system(rsy), .cpu_req(cpu_req), .cpu_write(cpu_write), .cpu_fetch(cpu_fetch),
	.cpu_addr(cpu_addr), .mmu_write(mw), .mmu_idx(2'h0), .mmu_base(20'hc0200),
	.mmu_limit(20'hc0300), .mmu_allow_write(1'h1), .cop_req(cop_req), .cop_addr(cop_addr),
	.cpu_mode(mode), .privileged(priv), .cpu_grant(grant), .cpu_fault(fault), .cop_grant(cgrant),
	.cop_fault(cfault), .redirect_valid(rv), .redirect_addr(raddr), .test_disabled(td),
	.health_self_test(hst), .health_ident(hid), .pdc_accept(pacc), .pdc_refused(pref));
core_model core_model_inst (.core_clk(core_clk), .go(go), .fetch(fetch), .write(write),
	.addr(addr), .cop_go(cop_go), .cpu_req(cpu_req), .cpu_fetch(cpu_fetch),
	.cpu_write(cpu_write), .cpu_addr(cpu_addr), .cop_req(cop_req), .cop_addr(cop_addr));
////////////////////////////////////////
task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
	checks_done++;
	if (seen !== exp) begin
		err_count++;
		$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
	end
endtask
task automatic pulse(ref logic s);
	@(negedge core_clk);
	s = 1'h1;
	@(negedge core_clk);
	s = 1'h0;
endtask
// answer lands two falling edges after go because the model adds one stage
task automatic acc(input logic [19:0] a, input logic f, input logic w, input logic c);
	@(negedge core_clk);
	go <= !c;
	cop_go <= c;
	addr <= a;
	fetch <= f;
	write <= w;
	@(negedge core_clk);
	go <= 1'h0;
	cop_go <= 1'h0;
	@(negedge core_clk);
endtask
task automatic do_reset(input logic f);
	arst_n = 1'h0;
	fuse = f;
	repeat (3) @(negedge core_clk);
	arst_n = 1'h1;
	chk(mode, `MODE_BOOT);
	chk(priv, 1'h1);
endtask
task automatic t_boot;
	do_reset(1'h0);
	hen = 1'h1;
	pulse(hreq);
	chk(hst, 1'h1);
	hsel = 1'h1;
	pulse(hreq);
	chk(hid, 1'h1);
	pulse(bdone);
	chk(mode, `MODE_TEST);
	acc(20'h00010, 1'h0, 1'h1, 1'h0);
	chk(grant, 1'h1);
	pulse(pend);
	chk(mode, `MODE_SYSTEM);
	// the disable flag reaches its output one clock after the mode change
	@(negedge core_clk);
	chk(td, 1'h1);
endtask
task automatic t_fw;
	acc(20'h6011c, 1'h1, 1'h0, 1'h0);
	chk(grant, 1'h1);
	chk(mode, `MODE_FIRMWARE);
	chk(priv, 1'h1);
	acc(20'h00010, 1'h0, 1'h0, 1'h0);
	chk(fault, 1'h1);
	acc(20'h80200, 1'h0, 1'h1, 1'h0);
	chk(grant, 1'h1);
	acc(20'hc01fc, 1'h0, 1'h1, 1'h0);
	chk(grant, 1'h1);
	acc(20'hc0200, 1'h0, 1'h0, 1'h0);
	chk(fault, 1'h1);
	pen = 1'h1;
	pulse(pwr);
	chk(pacc, 1'h1);
	plock = 1'h1;
	pulse(pwr);
	chk(pref, 1'h1);
	pulse(rsy);
	chk(mode, `MODE_SYSTEM);
endtask
task automatic t_sys;
	acc(20'h5fffc, 1'h0, 1'h0, 1'h0);
	chk(grant, 1'h1);
	acc(20'h60000, 1'h0, 1'h0, 1'h0);
	chk(fault, 1'h1);
	pulse(mw);
	pulse(rus);
	chk(mode, `MODE_USER);
	acc(20'hc02fc, 1'h0, 1'h1, 1'h0);
	chk(grant, 1'h1);
	acc(20'hc0300, 1'h0, 1'h0, 1'h0);
	chk(fault, 1'h1);
	exc_num = 2'h2;
	pulse(exc);
	chk(raddr, 20'h00008);
	chk(rv, 1'h1);
	chk(priv, 1'h0);
	chk(mode, `MODE_SYSTEM);
	pulse(rus);
	irq_num = 4'hf;
	pulse(irq);
	chk(raddr, 20'h0013c);
	chk(rv, 1'h1);
	pulse(rus);
	acc(20'h0027c, 1'h1, 1'h0, 1'h0);
	chk(mode, `MODE_SYSTEM);
endtask
task automatic t_cop;
	logic [19:0] ca [4] = '{20'hc1600, 20'hc207c, 20'hc2080, 20'hc0200};
	for (int i = 0; i < 4; i++) begin
		acc(ca[i], 1'h0, 1'h0, 1'h1);
		chk(cgrant, i < 2);
		chk(cfault, i >= 2);
	end
endtask
task automatic give_verdict;
	if (err_count == 0 && checks_done > 0) begin
		$display("STATUS OK");
	end else begin
		$display("STATUS NOT OK");
	end
	$finish;
endtask
////////////////////////////////////////
initial begin
	core_clk = 1'h0;
	forever #5 core_clk = ~core_clk;
end
initial begin
	#100000;
	err_count++;
	give_verdict();
end
initial begin
	{arst_n, fuse, pend, bdone, hen, hreq, hsel, pen, plock, pwr} = 10'h0;
	{exc, irq, rus, rsy, mw, go, fetch, write, cop_go} = 9'h0;
	{exc_num, irq_num, addr} = 26'h0;
	t_boot();
	t_fw();
	t_sys();
	t_cop();
	do_reset(1'h1);
	pulse(bdone);
	chk(mode, `MODE_SYSTEM);
	chk(td, 1'h1);
	give_verdict();
end
endmodule
`default_nettype wire
